// ===== fepc_map.svh
`ifndef FEPC_MAP_SVH
`define FEPC_MAP_SVH
`define FEPC_CMD_READ 8'h00
`define FEPC_CMD_ERASE 8'h20
`define FEPC_CMD_ERASE_VERIFY 8'ha0
`define FEPC_CMD_PROG_SETUP 8'h40
`define FEPC_CMD_PROG_VERIFY 8'hc0
`define FEPC_ERASED_BYTE 8'hff
`define FEPC_ERASE_PULSE_NS 10000000
`define FEPC_PROG_PULSE_NS 10000
`define FEPC_READ_WAIT_NS 6000
`define FEPC_CLK_NS 20
`define FEPC_ERASE_TRIES 1000
`define FEPC_PROG_TRIES 25
`define FEPC_STROBE_CYC 4
`define FEPC_CYC(ns) (((ns) + `FEPC_CLK_NS - 1) / `FEPC_CLK_NS)
`endif

// ===== fepc_pkg.sv
package fepc_pkg;
  typedef enum logic [1:0] {
    FEPC_OP_READ = 2'b00,
    FEPC_OP_PROGRAM = 2'b01,
    FEPC_OP_ERASE = 2'b10
  } fepc_op_t;
  typedef enum logic [1:0] {
    FEPC_BUS_IDLE = 2'b00,
    FEPC_BUS_WRITE = 2'b01,
    FEPC_BUS_READ = 2'b10
  } fepc_bus_t;
endpackage

// ===== fepc_bus_cycle.sv
`timescale 1ns/100ps
`include "fepc_map.svh"
// One write or read cycle on the flash pins, each phase held long enough
// that the device never sees a pulse near its glitch filter width.
module fepc_bus_cycle #(
  parameter int ADDR_W = 18,
  parameter int PHASE = `FEPC_STROBE_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire fepc_pkg::fepc_bus_t kind,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  output logic done,
  output logic [7:0] rdata,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  import fepc_pkg::*;
  initial begin
    // Read data needs three strobe cycles to clear the two-flop synchroniser
    if (PHASE < 3 || PHASE > 255) $error("PHASE out of range");
  end
  logic [1:0] ph_reg;
  logic [7:0] cnt_reg;
  logic [7:0] sync1_reg, sync2_reg;
  wire phase_end = cnt_reg == 8'(PHASE - 1);
  wire active = kind != FEPC_BUS_IDLE;
  assign done = active && ph_reg == 2'd2 && phase_end;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= flash_dq_in;
      sync2_reg <= sync1_reg;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ph_reg <= 2'd0;
      cnt_reg <= 8'h00;
      rdata <= 8'h00;
      flash_addr <= '0;
      flash_dq_out <= 8'h00;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end else if (!active) begin
      ph_reg <= 2'd0;
      cnt_reg <= 8'h00;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_dq_oe <= 1'b0;
    end else begin
      cnt_reg <= phase_end ? 8'h00 : cnt_reg + 8'h01;
      if (phase_end) ph_reg <= ph_reg == 2'd2 ? 2'd0 : ph_reg + 2'd1;
      unique case (ph_reg)
        2'd0: begin
          flash_addr <= addr;
          flash_dq_out <= wdata;
          flash_dq_oe <= kind == FEPC_BUS_WRITE;
          flash_ce_n <= 1'b0;
          flash_oe_n <= 1'b1;
        end
        2'd1: begin
          // Write only with oe high; read with we high
          flash_we_n <= kind != FEPC_BUS_WRITE;
          flash_oe_n <= kind != FEPC_BUS_READ;
        end
        default: begin
          // Synchroniser still holds the byte sampled while oe was low
          if (cnt_reg == 8'h00) rdata <= sync2_reg;
          flash_we_n <= 1'b1;
          flash_oe_n <= 1'b1;
          if (phase_end) flash_ce_n <= 1'b1;
          // Stop driving together with deselect, never onto a freed bus
          if (phase_end) flash_dq_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ===== fepc_ctrl.sv
`timescale 1ns/100ps
`include "fepc_map.svh"
// Functional notes
// - Host must program all bytes before bulk erase; user does that first.
// - Erase is two writes of the same erase code.
// - Wait the 10 ms erase pulse before erase-verify.
// - After a pass, erase-verify the next address in order.
// - On erase fail repeat erase, at most 1000 times.
// - Program is set-up write then program write with address and data.
// - Wait the 10 us program pulse before program-verify.
// - On mismatch repeat program, at most 25 attempts.
// - Erase set-up and erase both use code 20h.
// - Erase-verify is code a0h with the byte address.
// - Writing 00h selects read; wait 6 us before reading.
module fepc_ctrl #(
  parameter int ADDR_W = 18,
  parameter int ERASE_WAIT = `FEPC_CYC(`FEPC_ERASE_PULSE_NS),
  parameter int PROG_WAIT = `FEPC_CYC(`FEPC_PROG_PULSE_NS),
  parameter int READ_WAIT = `FEPC_CYC(`FEPC_READ_WAIT_NS),
  parameter int ERASE_TRIES = `FEPC_ERASE_TRIES,
  parameter int PROG_TRIES = `FEPC_PROG_TRIES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire fepc_pkg::fepc_op_t req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [7:0] req_data,
  output logic resp_valid,
  output logic resp_ok,
  output logic [7:0] resp_data,
  output logic [ADDR_W-1:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n
);
  import fepc_pkg::*;
  initial begin
    if (ERASE_WAIT < 1 || PROG_WAIT < 1 || READ_WAIT < 1) $error("bad wait");
    if (ERASE_TRIES < 1 || PROG_TRIES < 1) $error("bad tries");
    if (ERASE_TRIES > 1023 || PROG_TRIES > 1023) $error("tries too wide");
    if (ERASE_WAIT > 2**24 || PROG_WAIT > 2**24 || READ_WAIT > 2**24)
      $error("wait too long");
  end
  typedef enum logic [3:0] {
    FEPC_IDLE = 4'b0000,
    FEPC_RD_CMD = 4'b0001,
    FEPC_RD_WAIT = 4'b0010,
    FEPC_RD_DATA = 4'b0011,
    FEPC_ER_SETUP = 4'b0100,
    FEPC_ER_GO = 4'b0101,
    FEPC_ER_WAIT = 4'b0110,
    FEPC_EV_CMD = 4'b0111,
    FEPC_EV_READ = 4'b1000,
    FEPC_PG_SETUP = 4'b1001,
    FEPC_PG_GO = 4'b1010,
    FEPC_PG_WAIT = 4'b1011,
    FEPC_PV_CMD = 4'b1100,
    FEPC_PV_READ = 4'b1101,
    FEPC_FINISH = 4'b1110
  } fepc_state_t;
  fepc_state_t state_reg, state_next;
  logic [23:0] wait_reg;
  logic [9:0] tries_reg;
  logic [ADDR_W-1:0] addr_reg, vaddr_reg;
  logic [7:0] data_reg;
  logic ok_reg;
  logic [7:0] rdata;
  logic cyc_done;
  fepc_bus_t kind;
  logic [7:0] wdata;
  logic [ADDR_W-1:0] baddr;
  wire waited = wait_reg == 24'h000000;
  wire last_addr = vaddr_reg == {ADDR_W{1'b1}};
  wire erased = rdata == `FEPC_ERASED_BYTE;
  wire prog_match = rdata == data_reg;
  wire erase_out = tries_reg == 10'(ERASE_TRIES);
  wire prog_out = tries_reg == 10'(PROG_TRIES);
  wire is_wait = state_reg == FEPC_RD_WAIT || state_reg == FEPC_ER_WAIT
    || state_reg == FEPC_PG_WAIT;
  wire is_read = state_reg == FEPC_RD_DATA || state_reg == FEPC_EV_READ
    || state_reg == FEPC_PV_READ;
  assign req_ready = state_reg == FEPC_IDLE;
  assign resp_valid = state_reg == FEPC_FINISH;
  assign resp_ok = ok_reg;
  assign resp_data = data_reg;
  assign kind = (state_reg == FEPC_IDLE || state_reg == FEPC_FINISH || is_wait)
    ? FEPC_BUS_IDLE : (is_read ? FEPC_BUS_READ : FEPC_BUS_WRITE);
  // Address only matters on verify, program and array reads
  assign baddr = state_reg == FEPC_EV_CMD ? vaddr_reg : addr_reg;
  always_comb begin
    unique case (state_reg)
      FEPC_RD_CMD: wdata = `FEPC_CMD_READ;
      FEPC_ER_SETUP, FEPC_ER_GO: wdata = `FEPC_CMD_ERASE;
      FEPC_EV_CMD: wdata = `FEPC_CMD_ERASE_VERIFY;
      FEPC_PG_SETUP: wdata = `FEPC_CMD_PROG_SETUP;
      FEPC_PV_CMD: wdata = `FEPC_CMD_PROG_VERIFY;
      default: wdata = data_reg;
    endcase
  end
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      FEPC_IDLE:
        if (req_valid) begin
          unique case (req_op)
            FEPC_OP_PROGRAM: state_next = FEPC_PG_SETUP;
            FEPC_OP_ERASE: state_next = FEPC_ER_SETUP;
            default: state_next = FEPC_RD_CMD;
          endcase
        end
      FEPC_RD_CMD: if (cyc_done) state_next = FEPC_RD_WAIT;
      FEPC_RD_WAIT: if (waited) state_next = FEPC_RD_DATA;
      FEPC_RD_DATA: if (cyc_done) state_next = FEPC_FINISH;
      FEPC_ER_SETUP: if (cyc_done) state_next = FEPC_ER_GO;
      FEPC_ER_GO: if (cyc_done) state_next = FEPC_ER_WAIT;
      FEPC_ER_WAIT: if (waited) state_next = FEPC_EV_CMD;
      FEPC_EV_CMD: if (cyc_done) state_next = FEPC_EV_READ;
      FEPC_EV_READ:
        if (cyc_done) begin
          if (erased) state_next = last_addr ? FEPC_RD_CMD : FEPC_EV_CMD;
          else state_next = erase_out ? FEPC_RD_CMD : FEPC_ER_SETUP;
        end
      FEPC_PG_SETUP: if (cyc_done) state_next = FEPC_PG_GO;
      FEPC_PG_GO: if (cyc_done) state_next = FEPC_PG_WAIT;
      FEPC_PG_WAIT: if (waited) state_next = FEPC_PV_CMD;
      FEPC_PV_CMD: if (cyc_done) state_next = FEPC_PV_READ;
      FEPC_PV_READ:
        if (cyc_done) begin
          if (prog_match || prog_out) state_next = FEPC_RD_CMD;
          else state_next = FEPC_PG_SETUP;
        end
      FEPC_FINISH: state_next = FEPC_IDLE;
      default: state_next = FEPC_IDLE;
    endcase
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) state_reg <= FEPC_IDLE;
    else state_reg <= state_next;
  end
  // Wait counters load on the last write cycle, rounded up by FEPC_CYC
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_reg <= 24'h000000;
    end else if (cyc_done && state_reg == FEPC_ER_GO) begin
      wait_reg <= 24'(ERASE_WAIT - 1);
    end else if (cyc_done && state_reg == FEPC_PG_GO) begin
      wait_reg <= 24'(PROG_WAIT - 1);
    end else if (cyc_done && state_reg == FEPC_RD_CMD) begin
      wait_reg <= 24'(READ_WAIT - 1);
    end else if (!waited) begin
      wait_reg <= wait_reg - 24'h000001;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tries_reg <= 10'h000;
      addr_reg <= '0;
      vaddr_reg <= '0;
      data_reg <= 8'h00;
      ok_reg <= 1'b0;
    end else begin
      if (state_reg == FEPC_IDLE && req_valid) begin
        addr_reg <= req_addr;
        data_reg <= req_data;
        vaddr_reg <= '0;
        tries_reg <= 10'h000;
        // A plain read cannot fail; program and erase earn their status
        ok_reg <= req_op == FEPC_OP_READ;
      end
      if ((state_reg == FEPC_ER_GO || state_reg == FEPC_PG_GO) && cyc_done)
        tries_reg <= tries_reg + 10'h001;
      if (state_reg == FEPC_EV_READ && cyc_done) begin
        if (erased) vaddr_reg <= vaddr_reg + 1'b1;
        ok_reg <= erased && last_addr;
      end
      if (state_reg == FEPC_PV_READ && cyc_done) ok_reg <= prog_match;
      if (state_reg == FEPC_RD_DATA && cyc_done) data_reg <= rdata;
    end
  end
  fepc_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .clock(clock),
    .rst(rst),
    .kind(kind),
    .addr(baddr),
    .wdata(wdata),
    .done(cyc_done),
    .rdata(rdata),
    .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe),
    .flash_dq_in(flash_dq_in),
    .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n),
    .flash_we_n(flash_we_n)
  );
  property p_no_write_while_oe;
    @(posedge clock) disable iff (rst) !flash_we_n |-> flash_oe_n;
  endproperty
  a_no_write_while_oe: assert property (p_no_write_while_oe)
    else $error("we low while oe low");
  property p_drive_only_write;
    @(posedge clock) disable iff (rst)
      flash_dq_oe |-> !flash_ce_n && flash_oe_n;
  endproperty
  a_drive_only_write: assert property (p_drive_only_write)
    else $error("host drives data during read");
  property p_erase_wait;
    @(posedge clock) disable iff (rst)
      $rose(state_reg == FEPC_ER_WAIT) |-> wait_reg == 24'(ERASE_WAIT - 1);
  endproperty
  a_erase_wait: assert property (p_erase_wait)
    else $error("erase wait not loaded");
  property p_prog_wait;
    @(posedge clock) disable iff (rst)
      $rose(state_reg == FEPC_PG_WAIT) |-> wait_reg == 24'(PROG_WAIT - 1);
  endproperty
  a_prog_wait: assert property (p_prog_wait)
    else $error("program wait not loaded");
  property p_ev_after_wait;
    @(posedge clock) disable iff (rst)
      state_reg == FEPC_ER_WAIT && state_next == FEPC_EV_CMD |-> waited;
  endproperty
  a_ev_after_wait: assert property (p_ev_after_wait)
    else $error("verify before erase pulse ends");
  property p_erase_limit;
    @(posedge clock) disable iff (rst)
      state_reg == FEPC_EV_READ |-> tries_reg <= 10'(ERASE_TRIES);
  endproperty
  a_erase_limit: assert property (p_erase_limit)
    else $error("too many erase tries");
  property p_prog_limit;
    @(posedge clock) disable iff (rst)
      state_reg == FEPC_PV_READ |-> tries_reg <= 10'(PROG_TRIES);
  endproperty
  a_prog_limit: assert property (p_prog_limit)
    else $error("too many program tries");
  property p_erase_pair;
    @(posedge clock) disable iff (rst)
      state_reg == FEPC_ER_SETUP && state_next == FEPC_ER_GO
      |=> wdata == `FEPC_CMD_ERASE;
  endproperty
  a_erase_pair: assert property (p_erase_pair)
    else $error("second erase code differs");
  property p_read_wait;
    @(posedge clock) disable iff (rst)
      $rose(state_reg == FEPC_RD_WAIT) |-> wait_reg == 24'(READ_WAIT - 1);
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait not loaded");
endmodule

// ===== fepc_flash_model.sv
`timescale 1ns/100ps
`include "fepc_map.svh"
// Behavioural flash part on the far side of the pins; clockless like the real
// part, keyed to control-pin edges and measured delays.
module fepc_flash_model #(
  parameter int ADDR_W = 4,
  parameter int ERASE_NS = 400,
  parameter int PROG_NS = `FEPC_PROG_PULSE_NS,
  parameter int READ_NS = `FEPC_READ_WAIT_NS
) (
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] host_dq,
  input wire logic host_oe,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [31:0] erase_bad,
  input wire logic [31:0] prog_bad,
  output logic [7:0] dq,
  output logic [31:0] erase_cnt,
  output logic [31:0] prog_cnt,
  output logic [31:0] viol_cnt
);
  typedef enum logic [2:0] {
    M_READ, M_ESET, M_ERASE, M_EVER, M_PSET, M_PROG, M_PVER
  } fepc_mode_t;
  logic [7:0] mem [2**ADDR_W];
  fepc_mode_t mode;
  logic [ADDR_W-1:0] op_addr;
  logic [7:0] rd;
  logic [7:0] last_rd;
  logic skip_first;
  logic drive;
  realtime t_cmd;
  realtime t_fall;
  initial begin
    mode = M_READ;
    t_cmd = 0;
    t_fall = 0;
    last_rd = 8'h00;
    erase_cnt = 0;
    prog_cnt = 0;
    viol_cnt = 0;
    skip_first = 1'b0;
    for (int i = 0; i < 2**ADDR_W; i++) begin
      mem[i] = 8'h3c + 8'(i);
    end
    #1 skip_first = !we_n && !ce_n && oe_n;
  end
  assign drive = !ce_n && !oe_n;
  // Released bus shows the inverse of the last byte, never a stale match
  assign dq = host_oe ? host_dq : (drive ? rd : ~last_rd);
  always @(rd or drive) if (drive) last_rd = rd;
  always @(negedge oe_n or addr or mode) begin
    case (mode)
      M_EVER, M_PVER: rd = mem[op_addr];
      default: rd = ($realtime - t_cmd >= READ_NS) ? mem[addr] : ~mem[addr];
    endcase
  end
  always @(negedge we_n) t_fall = $realtime;
  // Operations run on regardless of ce_n; only a new command ends them
  always @(posedge we_n) begin
    if (skip_first) begin
      skip_first = 1'b0;
    end else if (!ce_n && oe_n && $realtime - t_fall >= 10.0) begin
      if (!host_oe) viol_cnt++;
      take(host_dq);
    end else if (!ce_n) begin
      viol_cnt++;
    end
  end
  task automatic take(input logic [7:0] d);
    if (mode == M_PSET) begin
      prog_cnt++;
      if (prog_cnt > prog_bad) mem[addr] = mem[addr] & d;
      op_addr = addr;
      t_cmd = $realtime;
      mode = M_PROG;
    end else begin
      case (d)
        `FEPC_CMD_ERASE: begin
          if (mode == M_ESET) begin
            erase_cnt++;
            t_cmd = $realtime;
            mode = M_ERASE;
          end else begin
            for (int i = 0; i < 2**ADDR_W; i++) if (mem[i] !== 8'h00) viol_cnt++;
            mode = M_ESET;
          end
        end
        `FEPC_CMD_ERASE_VERIFY: begin
          // Stop timer: a late verify never over-erases
          if (mode == M_ERASE) begin
            if ($realtime - t_cmd < ERASE_NS) viol_cnt++;
            else if (erase_cnt > erase_bad) foreach (mem[i]) mem[i] = `FEPC_ERASED_BYTE;
          end
          op_addr = addr;
          mode = M_EVER;
        end
        `FEPC_CMD_PROG_SETUP: mode = M_PSET;
        `FEPC_CMD_PROG_VERIFY: begin
          if (mode == M_PROG && $realtime - t_cmd < PROG_NS) viol_cnt++;
          mode = M_PVER;
        end
        default: begin
          mode = M_READ;
          t_cmd = $realtime;
        end
      endcase
    end
  endtask
endmodule

// ===== fepc_tb.sv
`timescale 1ns/100ps
module tb;
  import fepc_pkg::*;
  localparam int AW = 4;
  localparam int EW = 20;
  localparam int ET = 5;
  localparam int LIMIT = 100000;
  logic clock, rst, req_valid, req_ready, resp_valid, resp_ok;
  fepc_op_t req_op;
  logic [AW-1:0] req_addr, flash_addr;
  logic [7:0] req_data, resp_data, flash_dq_out, dq;
  logic flash_dq_oe, flash_ce_n, flash_oe_n, flash_we_n;
  logic [31:0] erase_bad, prog_bad, erase_cnt, prog_cnt, viol_cnt, base;
  int error_cnt, checked, cyc;
  fepc_ctrl #(.ADDR_W(AW), .ERASE_WAIT(EW), .ERASE_TRIES(ET)) i_fepc_ctrl (
    .clock(clock), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .resp_valid(resp_valid), .resp_ok(resp_ok), .resp_data(resp_data),
    .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
    .flash_dq_oe(flash_dq_oe), .flash_dq_in(dq), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
  fepc_flash_model #(.ADDR_W(AW), .ERASE_NS(EW * 20)) i_fepc_flash_model (
    .addr(flash_addr), .host_dq(flash_dq_out), .host_oe(flash_dq_oe),
    .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n),
    .erase_bad(erase_bad), .prog_bad(prog_bad), .dq(dq),
    .erase_cnt(erase_cnt), .prog_cnt(prog_cnt), .viol_cnt(viol_cnt));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      stop_test;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask
  // Holds the request until taken, then waits for the one-cycle answer
  task automatic run_op(input fepc_op_t op, input logic [AW-1:0] a,
                        input logic [7:0] d, input logic ok,
                        input logic [7:0] exp_data);
    @(posedge clock);
    #1;
    req_op = op;
    req_addr = a;
    req_data = d;
    req_valid = 1'b1;
    @(posedge clock);
    while (req_ready !== 1'b1) @(posedge clock);
    #1;
    req_valid = 1'b0;
    while (resp_valid !== 1'b1) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1;
    chk(resp_ok, ok, "status");
    chk(resp_data, exp_data, "data");
  endtask
  task automatic t_read;
    run_op(FEPC_OP_READ, 4'h0, 8'h00, 1'b1, 8'h3c);
    run_op(FEPC_OP_READ, 4'hf, 8'h00, 1'b1, 8'h4b);
  endtask
  task automatic t_preprog;
    for (int a = 0; a < 2**AW; a++) begin
      prog_bad = prog_cnt;
      run_op(FEPC_OP_PROGRAM, AW'(a), 8'h00, 1'b1, 8'h00);
    end
  endtask
  task automatic t_erase_fail;
    base = erase_cnt;
    erase_bad = erase_cnt + 100;
    run_op(FEPC_OP_ERASE, 4'h0, 8'h00, 1'b0, 8'h00);
    chk(erase_cnt, base + ET, "erase pulses on failure");
  endtask
  task automatic t_erase_ok;
    base = erase_cnt;
    erase_bad = erase_cnt + 1;
    run_op(FEPC_OP_ERASE, 4'h0, 8'h00, 1'b1, 8'hff);
    chk(erase_cnt, base + 2, "erase pulses on retry");
    run_op(FEPC_OP_READ, 4'h9, 8'h00, 1'b1, 8'hff);
  endtask
  task automatic t_prog_retry;
    base = prog_cnt;
    prog_bad = prog_cnt + 2;
    run_op(FEPC_OP_PROGRAM, 4'h6, 8'h5a, 1'b1, 8'h5a);
    chk(prog_cnt, base + 3, "program pulses on retry");
  endtask
  task automatic t_prog_fail;
    base = prog_cnt;
    prog_bad = prog_cnt + 100;
    run_op(FEPC_OP_PROGRAM, 4'h7, 8'h12, 1'b0, 8'hff);
    chk(prog_cnt, base + 25, "program pulses on failure");
    run_op(FEPC_OP_READ, 4'h6, 8'h00, 1'b1, 8'h5a);
  endtask
  initial begin
    error_cnt = 0;
    checked = 0;
    cyc = 0;
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = FEPC_OP_READ;
    req_addr = '0;
    req_data = 8'h00;
    erase_bad = 0;
    prog_bad = 0;
    base = 0;
    repeat (8) @(posedge clock);
    #1 rst = 1'b0;
    t_read();
    t_preprog();
    t_erase_fail();
    t_erase_ok();
    t_prog_retry();
    t_prog_fail();
    chk(viol_cnt, 32'h0, "pin protocol faults");
    stop_test();
  end
endmodule
